// file: src/rvp_cfg.svh
`ifndef RVP_CFG_SVH
`define RVP_CFG_SVH

// ****************
// Address space of the program ROM
// ****************
`define RVP_ROM_AW        13
`define RVP_ROM_TOP       13'h1fff
`define RVP_VER1_AW       14
`define RVP_GROUP_LEN     16

// ****************
// Pin levels sampled during reset that select a verification mode
// ****************
`define RVP_VER1_STROBE   1'b0
`define RVP_VER1_ALE      1'b1
`define RVP_VER1_EXTSEL   1'b1
`define RVP_VER2_STROBE   1'b0
`define RVP_VER2_ALE      1'b0
`define RVP_VER2_EXTSEL   1'b1

// ****************
// Timing in clock phase periods and reset values
// ****************
`define RVP_ALE_PERIOD    2'h3
`define RVP_LAST_PHASE    2'h2
`define RVP_INVALID_BYTE  8'hff
`define RVP_FIFO_DEPTH    32

`endif

// file: src/rvp_pkg.sv
package rvp_pkg;

    typedef enum logic [1:0] {
        RVP_MODE_NORMAL = 2'b00,
        RVP_MODE_VER1   = 2'b01,
        RVP_MODE_VER2   = 2'b10,
        RVP_MODE_DONE   = 2'b11
    } rvp_mode_e;

    // One captured reference byte on its way to the comparator.
    typedef struct packed {
        logic [12:0] addr;
        logic [7:0]  data;
        logic        last;
    } rvp_cmp_s;

    // A code read request from the fetch unit.
    typedef struct packed {
        logic        req;
        logic        ext;
        logic [15:0] addr;
    } rvp_code_req_s;

endpackage

// file: src/rvp_rom.sv
`timescale 1ns/1ps

// Mask ROM array. The load port stands for mask programming; the read
// data always come from a register, one cycle after the address.
module rvp_rom #(
    parameter int AW = 13,
    parameter int DW = 8
) (
    input  wire logic          core_clk_i,
    input  wire logic          load_we_i,
    input  wire logic [AW-1:0] load_addr_i,
    input  wire logic [DW-1:0] load_data_i,
    input  wire logic [AW-1:0] rd_addr_i,
    output logic      [DW-1:0] rd_data_o
);

    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge core_clk_i) begin
        if (load_we_i) begin
            mem[load_addr_i] <= load_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end

endmodule // rvp_rom

// file: src/rvp_fifo.sv
`timescale 1ns/1ps

module rvp_fifo #(
    parameter int W     = 22,
    parameter int DEPTH = 32
) (
    input  wire logic         core_clk_i,
    input  wire logic         sys_rst_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic      [W-1:0] out_data_o
);

    localparam int PW = $clog2(DEPTH);

    logic [W-1:0] mem [0:DEPTH-1];
    logic [PW:0]  wr_ptr_r;
    logic [PW:0]  rd_ptr_r;
    wire          empty = (wr_ptr_r == rd_ptr_r);
    wire          full  = (wr_ptr_r[PW] != rd_ptr_r[PW]) &&
                          (wr_ptr_r[PW-1:0] == rd_ptr_r[PW-1:0]);
    wire          push  = in_valid_i && !full;
    wire          pop   = out_ready_i && !empty;

    assign in_ready_o  = !full;
    assign out_valid_o = !empty;
    assign out_data_o  = mem[rd_ptr_r[PW-1:0]];

    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem[wr_ptr_r[PW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end

endmodule // rvp_fifo

// file: src/rvp_top.sv
`timescale 1ns/1ps
`include "rvp_cfg.svh"

// Overview of operation
// [R1] Protection type fixed at build, never changeable
// [R2] Verify mode 1 drives addressed byte on port0
// [R3] Tester applies 14-bit address on port1/port2
// [R4] Tester holds strobe, ALE, select, reset levels
// [R5] Tester runs crystal clock, pulls up port0
// [R6] Verify mode 2 starts at reset release
// [R7] ALE pulses every three phases, one byte each
// [R8] Address pointer starts zero, increments per pulse
// [R9] No address driven out during mode 2
// [R10] Partner supplies byte zero at first ALE
// [R11] Capture port0 three phases after ALE rise
// [R12] Mismatch sets error record until reported
// [R13] Every 16 bytes drive group pass/fail level
// [R14] Partner keeps crystal clock running in mode 2
// [R15] After last byte, emit program store strobe pulses
// [R16] Partner samples result at ALE falling edge
// [R17] External code reads of protected ROM invalid
// [R18] Latch access select at reset release
// [R19] Strobe pins are inputs while reset held
// [R20] ROM spans 0 to 1fff, run ends there
// [R21] Error record cleared for each new group
// [R22] Outside mode 2 result pin is normal port
module rvp_top #(
    // [R1] Protection type is a build-time option.
    parameter bit ROM_PROTECTED = 1'b1
) (
    input  wire logic                        core_clk_i,
    input  wire logic                        sys_rst_i,
    input  wire logic                        reset_pin_n_i,
    input  wire logic                        crystal_pins_i,
    input  wire logic                        external_access_select_i,
    input  wire logic                        ale_pin_i,
    output logic                             ale_pin_o,
    output logic                             ale_pin_oe_o,
    input  wire logic                        program_store_strobe_n_i,
    output logic                             program_store_strobe_n_o,
    output logic                             program_store_strobe_oe_o,
    input  wire logic [7:0]                  port0_i,
    output logic      [7:0]                  port0_o,
    output logic                             port0_oe_o,
    input  wire logic [7:0]                  port1_i,
    input  wire logic [7:0]                  port2_i,
    input  wire logic                        result_port_latch_i,
    input  wire logic                        result_port_oe_i,
    output logic                             verify_result_pin_o,
    output logic                             verify_result_pin_oe_o,
    input  wire rvp_pkg::rvp_code_req_s      code_req_i,
    output logic      [7:0]                  code_rd_data_o,
    output logic                             code_rd_valid_o,
    input  wire logic                        rom_load_we_i,
    input  wire logic [`RVP_ROM_AW-1:0]      rom_load_addr_i,
    input  wire logic [7:0]                  rom_load_data_i,
    output logic                             verify_mode_o
);
    import rvp_pkg::*;

    // ****************
    // Pin synchronisers
    // ****************
    // Every pin passes two flops; only the second stage is read.
    localparam int SW = 1 + 1 + 1 + 1 + 1 + 8 + 8 + 8;
    logic [SW-1:0] pin_s1_r;
    logic [SW-1:0] pin_s2_r;
    logic          crystal_pins_d_r;
    logic          rst_n_d_r;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
        end else begin
            pin_s1_r <= {reset_pin_n_i, crystal_pins_i, external_access_select_i,
                         ale_pin_i, program_store_strobe_n_i, port0_i, port1_i,
                         port2_i};
            pin_s2_r <= pin_s1_r;
        end
    end

    wire       rst_n_s  = pin_s2_r[28];
    wire       crystal_pins_s   = pin_s2_r[27];
    wire       extsel_s = pin_s2_r[26];
    wire       ale_s    = pin_s2_r[25];
    wire       program_store_strobe_s   = pin_s2_r[24];
    wire [7:0] p0_s     = pin_s2_r[23:16];
    wire [7:0] p1_s     = pin_s2_r[15:8];
    wire [7:0] p2_s     = pin_s2_r[7:0];

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            crystal_pins_d_r  <= 1'b0;
            rst_n_d_r <= 1'b0;
        end else begin
            crystal_pins_d_r  <= crystal_pins_s;
            rst_n_d_r <= rst_n_s;
        end
    end

    // One clock phase period per rising edge seen on the crystal pin.
    wire phase_tick  = crystal_pins_s && !crystal_pins_d_r;
    wire rst_release = rst_n_s && !rst_n_d_r;

    // ****************
    // Mode selection
    // ****************
    // [R19] Strobe pins read as mode straps while reset is held.
    wire ver1_strap = (program_store_strobe_s == `RVP_VER1_STROBE) && (ale_s == `RVP_VER1_ALE) &&
                      (extsel_s == `RVP_VER1_EXTSEL);
    wire ver2_strap = (program_store_strobe_s == `RVP_VER2_STROBE) && (ale_s == `RVP_VER2_ALE) &&
                      (extsel_s == `RVP_VER2_EXTSEL);

    rvp_mode_e mode_r;
    rvp_mode_e mode_nxt;
    logic      ver2_strap_r;
    logic      extsel_lat_r;
    logic      seq_end_r;
    logic      cmp_end_r;

    // A protected part refuses mode 1, an unprotected part mode 2.
    always_comb begin
        mode_nxt = mode_r;
        if (!rst_n_s) begin
            mode_nxt = (ver1_strap && !ROM_PROTECTED) ? RVP_MODE_VER1 : RVP_MODE_NORMAL;
        end else if (rst_release) begin
            // [R6] Mode 2 begins on reset release.
            mode_nxt = (ver2_strap_r && ROM_PROTECTED) ? RVP_MODE_VER2 : RVP_MODE_NORMAL;
        end else if (mode_r == RVP_MODE_VER2 && cmp_end_r) begin
            mode_nxt = RVP_MODE_DONE;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            mode_r       <= RVP_MODE_NORMAL;
            ver2_strap_r <= 1'b0;
            extsel_lat_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            if (!rst_n_s) begin
                ver2_strap_r <= ver2_strap;
            end
            // [R18] Access select latched at reset release.
            if (rst_release) begin
                extsel_lat_r <= extsel_s;
            end
        end
    end

    wire in_ver2 = (mode_r == RVP_MODE_VER2);
    wire in_done = (mode_r == RVP_MODE_DONE);
    wire in_ver1 = (mode_r == RVP_MODE_VER1);
    wire running = in_ver2 && !seq_end_r;

    // ****************************************************************
    // Mode 2 sequencer
    // ****************************************************************
    logic [1:0]             phase_r;
    logic                   primed_r;
    logic [`RVP_ROM_AW-1:0] ptr_r;
    rvp_cmp_s               push_item;
    logic                   fifo_in_ready;

    wire at_last  = (phase_r == `RVP_LAST_PHASE);
    // [R11] Capture port0 three phases after ALE rise.
    wire capture  = running && phase_tick && at_last && primed_r;
    // A full queue holds the sequencer in its last phase, stretching ALE low.
    wire adv      = phase_tick && (!at_last || !primed_r || fifo_in_ready);

    assign push_item.addr = ptr_r;
    assign push_item.data = p0_s;
    assign push_item.last = (ptr_r == `RVP_ROM_TOP);

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || !(in_ver2 || in_done)) begin
            phase_r   <= `RVP_LAST_PHASE;
            primed_r  <= 1'b0;
            ptr_r     <= '0;
            seq_end_r <= 1'b0;
        end else if (adv) begin
            // [R7] ALE period of three phases.
            phase_r <= at_last ? 2'h0 : phase_r + 2'h1;
            if (at_last) begin
                primed_r <= 1'b1;
            end
            if (capture) begin
                // [R20] Run ends after the top ROM address.
                if (push_item.last) begin
                    seq_end_r <= 1'b1;
                end else begin
                    // [R8] Pointer advances once per ALE pulse.
                    ptr_r <= ptr_r + 1'b1;
                end
            end
        end
    end

    // ****************************************************************
    // Reference byte queue
    // ****************************************************************
    rvp_cmp_s pop_item;
    logic     fifo_out_valid;
    logic     cmp_busy_r;
    wire      pop = fifo_out_valid && !cmp_busy_r && in_ver2;

    rvp_fifo #(
        .W     ($bits(rvp_cmp_s)),
        .DEPTH (`RVP_FIFO_DEPTH)
    ) u_fifo (
        .core_clk_i  (core_clk_i),
        .sys_rst_i   (sys_rst_i || !in_ver2),
        .in_valid_i  (capture),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (push_item),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (!cmp_busy_r && in_ver2),
        .out_data_o  (pop_item)
    );

    // ****************************************************************
    // ROM and read port selection
    // ****************************************************************
    logic [7:0] rom_q;
    wire  [`RVP_ROM_AW-1:0] rom_raddr =
        in_ver1 ? {p2_s[`RVP_ROM_AW-9:0], p1_s[7:0]} :
        in_ver2 ? pop_item.addr :
                  code_req_i.addr[`RVP_ROM_AW-1:0];

    rvp_rom #(
        .AW (`RVP_ROM_AW),
        .DW (8)
    ) u_rom (
        .core_clk_i  (core_clk_i),
        .load_we_i   (rom_load_we_i),
        .load_addr_i (rom_load_addr_i),
        .load_data_i (rom_load_data_i),
        .rd_addr_i   (rom_raddr),
        .rd_data_o   (rom_q)
    );

    // ****************************************************************
    // Comparator and group result
    // ****************************************************************
    logic [7:0] ref_r;
    logic       last_r;
    logic [3:0] grp_cnt_r;
    logic       err_r;
    logic       result_r;

    wire mismatch   = cmp_busy_r && (rom_q != ref_r);
    wire group_done = cmp_busy_r && (grp_cnt_r == 4'(`RVP_GROUP_LEN - 1));

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || !(in_ver2 || in_done)) begin
            cmp_busy_r <= 1'b0;
            ref_r      <= '0;
            last_r     <= 1'b0;
            grp_cnt_r  <= '0;
            err_r      <= 1'b0;
            result_r   <= 1'b1;
            cmp_end_r  <= 1'b0;
        end else begin
            cmp_busy_r <= pop;
            if (pop) begin
                ref_r  <= pop_item.data;
                last_r <= pop_item.last;
            end
            if (cmp_busy_r) begin
                grp_cnt_r <= grp_cnt_r + 4'h1;
            end
            if (group_done) begin
                // [R13] Report the sixteen-byte group, held till next.
                result_r <= !(err_r || mismatch);
                // [R21] Error record cleared for the next group.
                err_r    <= 1'b0;
            end else if (mismatch) begin
                // [R12] Mismatch remembered until reported.
                err_r <= 1'b1;
            end
            if (cmp_busy_r && last_r) begin
                cmp_end_r <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Protected code reads
    // ****************************************************************
    logic code_vld_d_r;
    logic code_bad_d_r;
    // [R17] External code may not read protected ROM.
    wire  code_bad = ROM_PROTECTED &&
                     (code_req_i.ext || !extsel_lat_r) &&
                     (code_req_i.addr <= 16'(`RVP_ROM_TOP));

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            code_vld_d_r    <= 1'b0;
            code_bad_d_r    <= 1'b0;
            code_rd_valid_o <= 1'b0;
            code_rd_data_o  <= '0;
        end else begin
            code_vld_d_r    <= code_req_i.req && (mode_r == RVP_MODE_NORMAL);
            code_bad_d_r    <= code_bad;
            code_rd_valid_o <= code_vld_d_r;
            code_rd_data_o  <= code_bad_d_r ? `RVP_INVALID_BYTE : rom_q;
        end
    end

    // ****************************************************************
    // Pin drivers
    // ****************************************************************
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            ale_pin_o                 <= 1'b0;
            ale_pin_oe_o              <= 1'b0;
            program_store_strobe_n_o  <= 1'b1;
            program_store_strobe_oe_o <= 1'b0;
            port0_o                   <= '0;
            port0_oe_o                <= 1'b0;
            verify_result_pin_o       <= 1'b1;
            verify_result_pin_oe_o    <= 1'b0;
            verify_mode_o             <= 1'b0;
        end else begin
            // [R19] Strobes released while reset pin is low.
            ale_pin_oe_o              <= rst_n_s && (in_ver2 || in_done);
            program_store_strobe_oe_o <= rst_n_s && (in_ver2 || in_done);
            // [R7] ALE high during phase zero of each period.
            ale_pin_o <= running && primed_r && (phase_r == 2'h0);
            // [R15] Strobe pulses mark the end of the run.
            program_store_strobe_n_o <= !(in_done && (phase_r == 2'h0));
            // [R2] Addressed byte on port0 in mode 1.
            // [R9] Port0 only listens during mode 2.
            port0_o    <= rom_q;
            port0_oe_o <= in_ver1;
            // [R22] Normal port function outside mode 2.
            verify_result_pin_o    <= (in_ver2 || in_done) ? result_r : result_port_latch_i;
            verify_result_pin_oe_o <= (in_ver2 || in_done) ? 1'b1 : result_port_oe_i;
            verify_mode_o          <= in_ver1 || in_ver2 || in_done;
        end
    end

endmodule // rvp_top

// file: tb/rvp_checker.sv
`timescale 1ns/1ps
`include "rvp_cfg.svh"

// ****************
// Port checker
// ****************
module rvp_checker #(
    parameter bit ROM_PROTECTED = 1'b1
) (
    input wire logic                   core_clk_i,
    input wire logic                   sys_rst_i,
    input wire logic                   reset_pin_n_i,
    input wire logic                   external_access_select_i,
    input wire logic                   ale_pin_i,
    input wire logic                   ale_pin_o,
    input wire logic                   ale_pin_oe_o,
    input wire logic                   program_store_strobe_n_i,
    input wire logic                   program_store_strobe_n_o,
    input wire logic                   program_store_strobe_oe_o,
    input wire logic                   port0_oe_o,
    input wire logic                   result_port_latch_i,
    input wire logic                   result_port_oe_i,
    input wire logic                   verify_result_pin_o,
    input wire logic                   verify_result_pin_oe_o,
    input wire rvp_pkg::rvp_code_req_s code_req_i,
    input wire logic [7:0]             code_rd_data_o,
    input wire logic                   code_rd_valid_o,
    input wire logic                   verify_mode_o
);
    import rvp_pkg::*;
    logic       ale_d_r;
    logic       seen_r;
    logic [7:0] cnt_r;
    logic       ale_rise;
    assign ale_rise = ale_pin_o & ~ale_d_r;
    // Cycles since last strobe rise, saturating.
    always_ff @(posedge core_clk_i) begin
        ale_d_r <= sys_rst_i ? 1'b0 : ale_pin_o;
        seen_r  <= (sys_rst_i | ~ale_pin_oe_o) ? 1'b0 : (seen_r | ale_rise);
        cnt_r   <= ale_rise ? 8'h00 : ((cnt_r == 8'hff) ? cnt_r : cnt_r + 8'h01);
    end
    default clocking dc @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    AST_NO_ADDR_OUT: assert property (ale_pin_oe_o |-> !port0_oe_o)
        else $error("port0 driven during internal walk");
    AST_ALE_HIGH: assert property ($rose(ale_pin_o) |-> ale_pin_o [*8] ##1 !ale_pin_o)
        else $error("strobe high time not one phase");
    AST_ALE_PERIOD: assert property (ale_rise && seen_r |-> cnt_r == 8'd23)
        else $error("strobe period not three phases");
    AST_STRAP_INPUT: assert property ((!reset_pin_n_i) [*6] |->
        !ale_pin_oe_o && !program_store_strobe_oe_o)
        else $error("strobe pins driven during reset");
    AST_NORMAL_PORT: assert property ((!verify_mode_o) [*4] |->
        verify_result_pin_o == $past(result_port_latch_i) &&
        verify_result_pin_oe_o == $past(result_port_oe_i))
        else $error("result pin not normal port");
    AST_RESULT_HOLD: assert property ($changed(verify_result_pin_o) &&
        ale_pin_oe_o && $past(ale_pin_oe_o, 2) |-> cnt_r <= 8'd10 || cnt_r == 8'd23)
        else $error("result pin moved mid group");
    AST_END_STROBE: assert property ($fell(program_store_strobe_n_o) |->
        (!program_store_strobe_n_o && !ale_pin_o) [*8] ##1 program_store_strobe_n_o)
        else $error("end strobe pulse wrong");
    AST_CODE_VALID: assert property (code_req_i.req && !verify_mode_o |->
        ##2 code_rd_valid_o)
        else $error("code read gave no valid");
    AST_CODE_HIDDEN: assert property (ROM_PROTECTED && code_req_i.req &&
        code_req_i.ext && code_req_i.addr <= 16'h1fff && !verify_mode_o |->
        ##2 code_rd_data_o == `RVP_INVALID_BYTE)
        else $error("protected byte leaked");
    AST_WALK_START: assert property ($rose(reset_pin_n_i) &&
        !program_store_strobe_n_i && !ale_pin_i && external_access_select_i |->
        ##6 verify_mode_o == ROM_PROTECTED)
        else $error("walk start wrong");
endmodule // rvp_checker

bind rvp_top rvp_checker #(.ROM_PROTECTED(ROM_PROTECTED)) rvp_checker_i (.*);

// file: tb/rvp_verifier.sv
`timescale 1ns/1ps

// ****************
// Verify circuit that computes reference bytes from its address counter
// ****************
module rvp_verifier (
    input  wire logic        ale_i,
    input  wire logic        en_i,
    input  wire logic        result_i,
    input  wire logic [12:0] err_addr_i,
    output logic             crystal_o,
    output logic [7:0]       port0_o,
    output logic [15:0]      cnt_o,
    output logic             res_o
);
    // free crystal
    // The crystal runs free with a 64 ns period, eight core clocks, each edge 1 ns after a core clock rising edge.
    initial begin
        crystal_o = 1'b0;
        #5;
        forever #32 crystal_o = ~crystal_o;
    end
    always @(posedge ale_i or negedge en_i) begin
        if (!en_i) begin
            cnt_o   <= 16'h0000;
            port0_o <= 8'h5a;
        end else begin
            port0_o <= cnt_o[7:0] ^ {cnt_o[12:8], 3'h5} ^ ((cnt_o[12:0] == err_addr_i) ? 8'hff : 8'h00);
            cnt_o   <= cnt_o + 16'h0001;
        end
    end
    always @(negedge ale_i) begin
        res_o <= result_i;
    end
endmodule // rvp_verifier

// file: tb/rom_verify_protect_tb.sv
`timescale 1ns/1ps

module rom_verify_protect_tb;
    import rvp_pkg::*;
    logic          clk;
    logic          sys_rst_i;
    logic          reset_pin_n_i;
    logic          external_access_select_i;
    logic          program_store_strobe_s;
    logic          ale_s;
    logic          pen;
    logic          result_port_latch_i;
    logic          result_port_oe_i;
    logic          rom_load_we_i;
    logic [7:0]    port1_i;
    logic [7:0]    port2_i;
    logic [7:0]    rom_load_data_i;
    logic [12:0]   rom_load_addr_i;
    logic [12:0]   err_a;
    rvp_code_req_s code_req_i;
    wire           crystal_pins;
    wire           res_seen;
    wire  [15:0]   acnt;
    wire  [7:0]    pref;
    wire           ale_o [2], ale_oe [2], ale_w [2], ps_o [2], ps_oe [2], ps_w [2];
    wire           p0_oe [2], res_o [2], res_oe [2], vld [2], vmode [2];
    wire  [7:0]    p0_o [2], p0_w [2], rdat [2];
    int            n_mismatch = 0;
    int            n_compared = 0;

    // ****************
    // Devices, index 0 protected and index 1 open
    // ****************
    for (genvar k = 0; k < 2; k++) begin : g
        assign ale_w[k] = ale_oe[k] ? ale_o[k] : ale_s;
        assign ps_w[k] = ps_oe[k] ? ps_o[k] : program_store_strobe_s;
        assign p0_w[k] = p0_oe[k] ? p0_o[k] : ((k == 0 && pen) ? pref : 8'hff);
        rvp_top #(.ROM_PROTECTED(k == 0)) rvp_top_i (
            .core_clk_i(clk), .sys_rst_i, .reset_pin_n_i, .crystal_pins_i(crystal_pins),
            .external_access_select_i, .ale_pin_i(ale_w[k]), .ale_pin_o(ale_o[k]),
            .ale_pin_oe_o(ale_oe[k]), .program_store_strobe_n_i(ps_w[k]),
            .program_store_strobe_n_o(ps_o[k]), .program_store_strobe_oe_o(ps_oe[k]),
            .port0_i(p0_w[k]), .port0_o(p0_o[k]), .port0_oe_o(p0_oe[k]), .port1_i,
            .port2_i, .result_port_latch_i, .result_port_oe_i,
            .verify_result_pin_o(res_o[k]), .verify_result_pin_oe_o(res_oe[k]),
            .code_req_i, .code_rd_data_o(rdat[k]), .code_rd_valid_o(vld[k]),
            .rom_load_we_i, .rom_load_addr_i, .rom_load_data_i, .verify_mode_o(vmode[k]));
    end
    rvp_verifier rvp_verifier_i (.ale_i(ale_w[0]), .en_i(pen), .result_i(res_o[0]),
        .err_addr_i(err_a), .crystal_o(crystal_pins), .port0_o(pref), .cnt_o(acnt),
        .res_o(res_seen));

    // ****************
    // Shared tasks
    // ****************
    function automatic logic [7:0] rv(input logic [12:0] a);
        return a[7:0] ^ {a[12:8], 3'h5};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic boot(input logic ps, input logic al, input logic sl);
        reset_pin_n_i = 1'b0;
        program_store_strobe_s = ps;
        ale_s = al;
        external_access_select_i = sl;
        repeat (40) @(negedge clk);
        reset_pin_n_i = 1'b1;
        repeat (10) @(negedge clk);
    endtask
    task automatic code_rd(input logic x, input logic [15:0] a, input logic [7:0] e0, e1);
        code_req_i = '{1'b1, x, a};
        @(negedge clk);
        code_req_i.req = 1'b0;
        @(posedge clk);
        #1;
        check({vld[0], rdat[0]}, {1'b1, e0});
        check({vld[1], rdat[1]}, {1'b1, e1});
        @(negedge clk);
    endtask
    task automatic wait_cnt(input logic [15:0] n, input logic exp);
        int t = 0;
        while (acnt != n && t < 2000) begin
            @(negedge clk);
            t++;
        end
        check(res_seen, exp);
        check(p0_oe[0], 1'b0);
    endtask

    // ****************
    // Scenarios
    // ****************
    task automatic t_mode1();
        logic [13:0] ad [4] = '{14'h0000, 14'h0001, 14'h2abc, 14'h1fff};
        reset_pin_n_i = 1'b0;
        {program_store_strobe_s, ale_s, external_access_select_i} = 3'b011;
        repeat (10) @(negedge clk);
        check(vmode[1], 1'b1);
        check(vmode[0], 1'b0);
        foreach (ad[i]) begin
            {port2_i, port1_i} = {2'b00, ad[i]};
            repeat (6) @(negedge clk);
            check(p0_w[1], rv(ad[i][12:0]));
            check(p0_oe[1], 1'b1);
        end
    endtask
    task automatic t_code();
        boot(1'b1, 1'b0, 1'b1);
        external_access_select_i = 1'b0;
        code_rd(1'b0, 16'h0010, rv(13'h0010), rv(13'h0010));
        code_rd(1'b1, 16'h1fff, 8'hff, rv(13'h1fff));
        boot(1'b1, 1'b0, 1'b0);
        external_access_select_i = 1'b1;
        code_rd(1'b0, 16'h0020, 8'hff, rv(13'h0020));
        result_port_latch_i = 1'b0;
        result_port_oe_i = 1'b1;
        repeat (4) @(negedge clk);
        check({res_o[0], res_oe[0]}, 2'b01);
        result_port_latch_i = 1'b1;
        result_port_oe_i = 1'b0;
    endtask
    task automatic t_mode2();
        err_a = 13'h0013;
        pen = 1'b1;
        boot(1'b0, 1'b0, 1'b1);
        check(vmode[0], 1'b1);
        check(vmode[1], 1'b0);
        wait_cnt(16'd18, 1'b1);
        wait_cnt(16'd34, 1'b0);
        wait_cnt(16'd50, 1'b1);
        reset_pin_n_i = 1'b0;
        pen = 1'b0;
        repeat (10) @(negedge clk);
        check(vmode[0], 1'b0);
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        complete_run();
    end
    initial begin
        sys_rst_i = 1'b1;
        reset_pin_n_i = 1'b0;
        external_access_select_i = 1'b1;
        program_store_strobe_s = 1'b1;
        ale_s = 1'b0;
        pen = 1'b0;
        result_port_latch_i = 1'b1;
        result_port_oe_i = 1'b0;
        rom_load_we_i = 1'b0;
        rom_load_addr_i = 13'h0000;
        rom_load_data_i = 8'h00;
        port1_i = 8'h00;
        port2_i = 8'h00;
        err_a = 13'h0000;
        code_req_i = '0;
        repeat (20) @(negedge clk);
        sys_rst_i = 1'b0;
        rom_load_we_i = 1'b1;
        for (int a = 0; a < 8192; a++) begin
            rom_load_addr_i = a[12:0];
            rom_load_data_i = rv(a[12:0]);
            @(negedge clk);
        end
        rom_load_we_i = 1'b0;
        t_mode1();
        t_code();
        t_mode2();
        complete_run();
    end
endmodule // rom_verify_protect_tb
